// file: include/tws_pkg.sv
// Purpose: shared constants for the two-wire slave receiver
// Assumes: apb register map of four aligned words
// Notes: status codes carry zero prescaler bits
package tws_pkg;
  // ==========================================================
  // register map
  localparam int unsigned APB_AW = 8;
  localparam int unsigned APB_DW = 32;
  localparam logic [7:0] OFS_OWN = 8'h00;
  localparam logic [7:0] OFS_CTL = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_DATA = 8'h0c;
  // ==========================================================
  // field positions
  localparam int unsigned CTL_IRQ = 7;
  localparam int unsigned CTL_ACK = 6;
  localparam int unsigned CTL_STA = 5;
  localparam int unsigned CTL_STO = 4;
  localparam int unsigned CTL_EN = 2;
  localparam int unsigned OWN_GC = 0;
  localparam logic [7:0] CTL_WMASK = 8'h74;
  localparam logic [7:0] STAT_MASK = 8'hf8;
  // ==========================================================
  // reset values
  localparam logic [7:0] RST_OWN = 8'h00;
  localparam logic [7:0] RST_CTL = 8'h00;
  localparam logic [7:0] RST_DATA = 8'hff;
  // ==========================================================
  // status codes
  localparam logic [7:0] ST_OWN_W = 8'h60;
  localparam logic [7:0] ST_ARB_OWN = 8'h68;
  localparam logic [7:0] ST_GC = 8'h70;
  localparam logic [7:0] ST_ARB_GC = 8'h78;
  localparam logic [7:0] ST_D_ACK = 8'h80;
  localparam logic [7:0] ST_D_NACK = 8'h88;
  localparam logic [7:0] ST_GD_ACK = 8'h90;
  localparam logic [7:0] ST_GD_NACK = 8'h98;
  localparam logic [7:0] ST_NONE = 8'hf8;
  localparam logic [3:0] BYTE_BITS = 4'd8;
  localparam logic [6:0] GC_ADDR = 7'h00;
  // ==========================================================
  // link states, gray along idle-addr-ack-hold-data
  typedef enum logic [2:0] {
    TWS_IDLE = 3'b000,
    TWS_ADDR = 3'b001,
    TWS_ACK = 3'b011,
    TWS_HOLD = 3'b010,
    TWS_DATA = 3'b110,
    TWS_SKIP = 3'b100
  } tws_state_type;
endpackage : tws_pkg

// file: design/tws_line_sync.sv
// Purpose: two-flop synchroniser and edge finder for bus lines
// Assumes: lines are asynchronous to clk
// Notes: edges come from the second and third stages only
`timescale 1ns/1ps
module tws_line_sync #(
  parameter int unsigned W = 2
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [W-1:0] line_in,
  output logic [W-1:0] level,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  logic [W-1:0] meta;
  logic [W-1:0] prev;
  // ==========================================================
  // per line stages
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_line
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          meta[i] <= 1'b1;
          level[i] <= 1'b1;
          prev[i] <= 1'b1;
        end else begin
          meta[i] <= line_in[i];
          level[i] <= meta[i];
          prev[i] <= level[i];
        end
      end
      assign rise[i] = level[i] & ~prev[i];
      assign fall[i] = ~level[i] & prev[i];
    end
  endgenerate
endmodule : tws_line_sync

// file: design/tws_slave_rx.sv
// Purpose: slave receiver of a two-wire serial unit with apb registers
// Assumes: open-drain bus lines, clk far faster than scl
// Notes: operation
// Operation
// - answer only when received seven-bit address equals own address upper bits
// - own address bit zero enables answering the general call address
// - matched address with write bit enters receive, read bit leaves for transmit
// - after own address plus write, set flag and present status
// - addressed for write after lost arbitration still enters receive mode
// - acknowledge enable cleared means next data byte gets not-acknowledge
// - acknowledge enable low: own address ignored, bus still watched
// - in deep sleep address match still works when acknowledge enabled
// - match in sleep wakes device, scl held low until flag cleared
// - data register need not hold last bus byte after wake
// - status codes read with prescaler bits zero
// - own address plus write acknowledged gives status 0x60
// - after lost arbitration report 0x68 own or 0x78 general call
// - general call acknowledged gives status 0x70
// - after address status flag clear, next byte acked per acknowledge enable
// - data byte received and acked gives status 0x80
// - status 0x88 on nack byte; clear leaves addressed mode
// - back in non-addressed mode general call honoured if enabled
// - start request with flag clear issues start once bus free
//
// Decided for this implementation: the register addresses and the APB slave port.
`timescale 1ns/1ps
module tws_slave_rx (
  input wire logic clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [tws_pkg::APB_AW-1:0] paddr,
  input wire logic [tws_pkg::APB_DW-1:0] pwdata,
  output logic [tws_pkg::APB_DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_n,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic sleep_mode,
  input wire logic arb_lost,
  output logic wake_req,
  output logic start_issue,
  output logic slave_tx_sel
);
  import tws_pkg::*;

  // ==========================================================
  // address decode
  function automatic logic reg_hit(input logic [APB_AW-1:0] a);
    reg_hit = (a == OFS_OWN) || (a == OFS_CTL) || (a == OFS_STAT) || (a == OFS_DATA);
  endfunction : reg_hit

  logic [7:0] own_slave_address;
  logic [7:0] serial_control_reg;
  logic [7:0] serial_status_reg;
  logic [7:0] serial_data_reg;
  logic [7:0] rdata;
  logic [7:0] next_own, next_ctl, next_stat, next_data, next_rdata;
  logic wr_en, rd_setup, flag_clr, resume, irq_flag, ack_enable;
  logic set_irq, rx_load;
  logic [7:0] stat_code;

  tws_state_type state, next_state;
  logic [3:0] bit_cnt, next_cnt;
  logic [7:0] shreg, next_sh;
  logic is_gc, next_gc, ack_sel, next_ack, nacked, next_nack;
  logic data_ph, next_dph, bus_idle, next_idle, start_pending, next_pend;
  logic sda_drv, next_sda, next_wake, next_issue, next_tx;
  logic [1:0] lvl, rise, fall;
  logic scl_rise, scl_fall, start_cond, stop_cond, gc_hit, own_hit, unit_on;

  // ==========================================================
  // bus line conditioning
  tws_line_sync #(.W(2)) u_sync (
    .clk(clk),
    .nrst(nrst),
    .line_in({sda_in, scl_in}),
    .level(lvl),
    .rise(rise),
    .fall(fall)
  );

  assign scl_rise = rise[0];
  assign scl_fall = fall[0];
  assign start_cond = lvl[0] & fall[1];
  assign stop_cond = lvl[0] & rise[1];
  assign irq_flag = serial_control_reg[CTL_IRQ];
  assign ack_enable = serial_control_reg[CTL_ACK];
  // acknowledge enable gates address recognition; sleep does not
  assign unit_on = serial_control_reg[CTL_EN] & ack_enable;
  assign gc_hit = (shreg[7:1] == GC_ADDR) & own_slave_address[OWN_GC];
  assign own_hit = (shreg[7:1] != GC_ADDR) & (shreg[7:1] == own_slave_address[7:1]);

  // ==========================================================
  // apb slave, zero wait states
  assign wr_en = psel & penable & pwrite & reg_hit(paddr);
  assign rd_setup = psel & ~penable & ~pwrite;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~reg_hit(paddr);
  assign prdata = {24'h000000, rdata};
  assign flag_clr = wr_en & (paddr == OFS_CTL) & pwdata[CTL_IRQ];
  assign resume = flag_clr & irq_flag;

  always_comb begin
    next_own = own_slave_address;
    next_ctl = serial_control_reg;
    next_stat = serial_status_reg;
    next_data = serial_data_reg;
    next_rdata = rdata;
    if (wr_en && paddr == OFS_OWN) begin
      next_own = pwdata[7:0];
    end
    if (wr_en && paddr == OFS_CTL) begin
      next_ctl = (serial_control_reg & ~CTL_WMASK) | (pwdata[7:0] & CTL_WMASK);
    end
    if (wr_en && paddr == OFS_DATA) begin
      next_data = pwdata[7:0];
    end
    // a flag set in the clearing cycle survives
    next_ctl[CTL_IRQ] = set_irq | (irq_flag & ~flag_clr);
    if (set_irq) begin
      next_stat = stat_code & STAT_MASK;
    end
    // address bytes never land here, so wake leaves old data
    if (rx_load) begin
      next_data = shreg;
    end
    if (rd_setup) begin
      case (paddr)
        OFS_OWN: next_rdata = own_slave_address;
        OFS_CTL: next_rdata = serial_control_reg;
        OFS_STAT: next_rdata = serial_status_reg;
        OFS_DATA: next_rdata = serial_data_reg;
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      own_slave_address <= RST_OWN;
      serial_control_reg <= RST_CTL;
      serial_status_reg <= ST_NONE;
      serial_data_reg <= RST_DATA;
      rdata <= 8'h00;
    end else begin
      own_slave_address <= next_own;
      serial_control_reg <= next_ctl;
      serial_status_reg <= next_stat;
      serial_data_reg <= next_data;
      rdata <= next_rdata;
    end
  end

  // ==========================================================
  // link state machine
  always_comb begin
    next_state = state;
    next_cnt = bit_cnt;
    next_sh = shreg;
    next_gc = is_gc;
    next_ack = ack_sel;
    next_nack = nacked;
    next_dph = data_ph;
    next_idle = bus_idle;
    next_pend = start_pending;
    next_sda = sda_drv;
    next_wake = 1'b0;
    next_issue = 1'b0;
    next_tx = 1'b0;
    set_irq = 1'b0;
    rx_load = 1'b0;
    stat_code = serial_status_reg;
    if (start_cond) begin
      next_state = TWS_ADDR;
      next_cnt = 4'd0;
      next_dph = 1'b0;
      next_idle = 1'b0;
      next_sda = 1'b0;
    end else if (stop_cond) begin
      next_state = TWS_IDLE;
      next_idle = 1'b1;
      next_sda = 1'b0;
    end else begin
      case (state)
        TWS_ADDR, TWS_DATA: begin
          if (scl_rise) begin
            next_sh = {shreg[6:0], lvl[1]};
            next_cnt = bit_cnt + 4'd1;
          end else if (scl_fall && bit_cnt == BYTE_BITS) begin
            if (state == TWS_DATA) begin
              next_state = TWS_ACK;
              next_sda = ack_sel;
            end else if (unit_on && (own_hit || gc_hit) && !shreg[0]) begin
              next_state = TWS_ACK;
              next_sda = 1'b1;
              next_ack = 1'b1;
              next_gc = gc_hit;
              next_wake = sleep_mode;
            end else begin
              next_state = TWS_SKIP;
              next_tx = unit_on & own_hit & shreg[0];
            end
          end
        end
        TWS_ACK: begin
          if (scl_fall) begin
            next_sda = 1'b0;
            next_state = TWS_HOLD;
            next_cnt = 4'd0;
            set_irq = 1'b1;
            next_nack = ~ack_sel;
            rx_load = data_ph;
            if (data_ph) begin
              stat_code = is_gc ? (ack_sel ? ST_GD_ACK : ST_GD_NACK)
                                : (ack_sel ? ST_D_ACK : ST_D_NACK);
            end else if (is_gc) begin
              stat_code = arb_lost ? ST_ARB_GC : ST_GC;
            end else begin
              stat_code = arb_lost ? ST_ARB_OWN : ST_OWN_W;
            end
          end
        end
        TWS_HOLD: begin
          if (resume) begin
            // start and ack choices ride on the very write that clears the flag
            if (nacked) begin
              next_state = TWS_SKIP;
              next_pend = pwdata[CTL_STA];
            end else begin
              next_state = TWS_DATA;
              next_dph = 1'b1;
              next_ack = pwdata[CTL_ACK];
            end
          end
        end
        TWS_IDLE, TWS_SKIP: begin
          if (start_pending && bus_idle) begin
            next_issue = 1'b1;
            next_pend = 1'b0;
          end
        end
        default: next_state = TWS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= TWS_IDLE;
      bit_cnt <= 4'd0;
      shreg <= 8'h00;
      is_gc <= 1'b0;
      ack_sel <= 1'b0;
      nacked <= 1'b0;
      data_ph <= 1'b0;
      bus_idle <= 1'b1;
      start_pending <= 1'b0;
      sda_drv <= 1'b0;
      wake_req <= 1'b0;
      start_issue <= 1'b0;
      slave_tx_sel <= 1'b0;
    end else begin
      state <= next_state;
      bit_cnt <= next_cnt;
      shreg <= next_sh;
      is_gc <= next_gc;
      ack_sel <= next_ack;
      nacked <= next_nack;
      data_ph <= next_dph;
      bus_idle <= next_idle;
      start_pending <= next_pend;
      sda_drv <= next_sda;
      wake_req <= next_wake;
      start_issue <= next_issue;
      slave_tx_sel <= next_tx;
    end
  end

  // clock stretch: a long wake-up keeps the whole bus blocked
  assign scl_out = 1'b0;
  assign scl_oe_n = ~(state == TWS_HOLD);
  assign sda_out = 1'b0;
  assign sda_oe_n = ~sda_drv;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  chk_hold_stretch: assert property (irq_flag |-> !scl_oe_n)
    else $error("scl not held while flag set");
  chk_own_status: assert property (state == TWS_ACK && scl_fall && !data_ph && !is_gc
    && !arb_lost |=> irq_flag && serial_status_reg == ST_OWN_W)
    else $error("own address status wrong");
  chk_gc_status: assert property (state == TWS_ACK && scl_fall && !data_ph && is_gc
    && !arb_lost |=> serial_status_reg == ST_GC)
    else $error("general call status wrong");
  chk_arb_status: assert property (state == TWS_ACK && scl_fall && !data_ph && arb_lost
    |=> serial_status_reg == (is_gc ? ST_ARB_GC : ST_ARB_OWN))
    else $error("lost arbitration status wrong");
  chk_no_ack_off: assert property (state == TWS_ADDR && !unit_on && !start_cond && !stop_cond
    |=> state != TWS_ACK)
    else $error("address acked with ack disabled");
  chk_gc_ignored: assert property (state == TWS_ADDR && scl_fall && bit_cnt == BYTE_BITS
    && !start_cond && !stop_cond && shreg[7:1] == GC_ADDR && !own_slave_address[OWN_GC]
    |=> state == TWS_SKIP)
    else $error("general call answered while disabled");
  chk_nack_next: assert property (state == TWS_HOLD && resume && !nacked && !pwdata[CTL_ACK]
    |=> state == TWS_DATA && !ack_sel)
    else $error("next byte not set to nack");
  chk_nack_status: assert property (state == TWS_ACK && scl_fall && data_ph && !ack_sel
    && !is_gc && !start_cond && !stop_cond |=> serial_status_reg == ST_D_NACK ##1 nacked)
    else $error("nack data status wrong");
  chk_ack_status: assert property (state == TWS_ACK && scl_fall && data_ph && ack_sel
    && !is_gc && !start_cond && !stop_cond
    |=> serial_status_reg == ST_D_ACK && serial_data_reg == $past(shreg))
    else $error("ack data status or byte wrong");
  chk_wake_pulse: assert property ($rose(wake_req) |-> state == TWS_ACK ##1 !wake_req)
    else $error("wake without match");
  chk_read_dir: assert property (slave_tx_sel |-> state == TWS_SKIP)
    else $error("read address entered receive");
  chk_presc_zero: assert property (serial_status_reg[2:0] == 3'h0)
    else $error("prescaler bits not zero");
endmodule : tws_slave_rx

// file: tb/tws_bus_master.sv
// Purpose: behavioural two-wire master transmitter facing the slave receiver
// Assumes: open-drain lines with pull-ups, 160 ns bus clock period
// Notes: waits while the slave stretches the clock
`timescale 1ns/1ps
module tws_bus_master (
  input wire logic scl_out,
  input wire logic scl_oe_n,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  output logic scl,
  output logic sda
);
  logic scl_m = 1'b1;
  logic sda_m = 1'b1;
  // ==========================================================
  // wired-and lines; a released line goes to the pull-up level
  assign scl = scl_m & (scl_oe_n ? 1'b1 : scl_out);
  assign sda = sda_m & (sda_oe_n ? 1'b1 : sda_out);
  // ==========================================================
  // bus conditions
  task bit_io(input logic b, output logic r);
    sda_m = b;
    #40;
    scl_m = 1'b1;
    wait (scl === 1'b1);
    #40;
    r = sda;
    #40;
    scl_m = 1'b0;
    #40;
  endtask : bit_io
  task start();
    sda_m = 1'b1;
    scl_m = 1'b1;
    wait (scl === 1'b1);
    #80;
    sda_m = 1'b0;
    #80;
    scl_m = 1'b0;
    #40;
  endtask : start
  task send(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], r);
    end
    // ack slot: the line is released so the slave decides it
    bit_io(1'b1, ack);
  endtask : send
  task stop();
    sda_m = 1'b0;
    #40;
    scl_m = 1'b1;
    wait (scl === 1'b1);
    #80;
    sda_m = 1'b1;
    #80;
  endtask : stop
endmodule : tws_bus_master

// file: tb/tb.sv
// Purpose: self-checking bench of the two-wire slave receiver
// Assumes: apb master and bus master are the stimulus sources, plus sleep_mode and arb_lost set by the bench
// Notes: expected read values go through a queue to a watching process
`timescale 1ns/1ps
module tb;
  import tws_pkg::*;
  logic clk = 1'b0;
  logic nrst, psel, penable, pwrite, sleep_mode, arb_lost;
  logic [APB_AW-1:0] paddr;
  logic [APB_DW-1:0] pwdata, prdata;
  logic pready, pslverr, scl_out, scl_oe_n, sda_out, sda_oe_n;
  logic wake_req, start_issue, slave_tx_sel, scl, sda, a;
  logic [6:0] own;
  logic [7:0] d;
  logic [32:0] rq[$];
  int errors = 0, checks = 0, n_wake = 0, n_start = 0, n_tx = 0;
  always #2 clk = ~clk;
  tws_slave_rx i_tws_slave_rx (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .scl_in(scl), .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_in(sda),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .sleep_mode(sleep_mode), .arb_lost(arb_lost),
    .wake_req(wake_req), .start_issue(start_issue), .slave_tx_sel(slave_tx_sel));
  tws_bus_master m_bus (.scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .scl(scl), .sda(sda));
  // ==========================================================
  // comparison and closing
  task check(input logic [32:0] got, input logic [32:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task end_sim();
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim
  // ==========================================================
  // watcher: read data and error flag, plus pulse counts
  always @(posedge clk) begin
    if (psel && penable && !pwrite && pready === 1'b1) check({pslverr, prdata}, rq.pop_front());
    if (wake_req === 1'b1) n_wake++;
    if (start_issue === 1'b1) n_start++;
    if (slave_tx_sel === 1'b1) n_tx++;
  end
  // ==========================================================
  // apb master
  task apb(input logic [7:0] ad, input logic w, input logic [7:0] wd, input logic [32:0] exp);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= ad;
    pwrite <= w;
    pwdata <= {24'h0, wd};
    if (!w) rq.push_back(exp);
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task rd(input logic [7:0] ad, input logic [7:0] exp);
    apb(ad, 1'b0, 8'h00, {25'h0, exp});
  endtask : rd
  task wr(input logic [7:0] ad, input logic [7:0] wd);
    apb(ad, 1'b1, wd, 33'h0);
  endtask : wr
  // ==========================================================
  // bus scenarios
  task tail(input logic [7:0] tst);
    wr(OFS_CTL, 8'h84);
    m_bus.send(d, a);
    check({32'h0, a}, 33'h1);
    rd(OFS_STAT, tst);
    wr(OFS_CTL, 8'hc4);
    m_bus.stop();
  endtask : tail
  task ok_case(input logic [7:0] b, input logic arb, input logic slp, input logic [7:0] st,
      input logic [7:0] tst);
    @(posedge clk);
    arb_lost <= arb;
    sleep_mode <= slp;
    m_bus.start();
    m_bus.send(b, a);
    check({32'h0, a}, 33'h0);
    check({32'h0, scl_oe_n}, 33'h0);
    rd(OFS_STAT, st);
    rd(OFS_CTL, 8'hc4);
    @(posedge clk);
    arb_lost <= 1'b0;
    sleep_mode <= 1'b0;
    tail(tst);
  endtask : ok_case
  task nack_case(input logic [7:0] b, input logic [7:0] st);
    m_bus.start();
    m_bus.send(b, a);
    check({32'h0, a}, 33'h1);
    m_bus.stop();
    // an ignored frame leaves the last status untouched
    rd(OFS_STAT, st);
  endtask : nack_case
  initial begin
    #200000;
    errors++;
    end_sim();
  end
  initial begin
    nrst <= 1'b0;
    {psel, penable, pwrite, sleep_mode, arb_lost} <= 5'h0;
    paddr <= 8'h00;
    pwdata <= 32'h0;
    own = 7'(($urandom(32'h8b634dc8) % 126) + 2);
    d = 8'($urandom);
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    rd(OFS_OWN, RST_OWN);
    rd(OFS_CTL, RST_CTL);
    rd(OFS_STAT, ST_NONE);
    rd(OFS_DATA, RST_DATA);
    apb(8'h10, 1'b0, 8'h00, {1'b1, 32'h0});
    wr(OFS_OWN, {own, 1'b1});
    wr(OFS_CTL, 8'h44);
    nack_case({own ^ 7'h01, 1'b0}, ST_NONE);
    m_bus.start();
    m_bus.send({own, 1'b0}, a);
    check({32'h0, a}, 33'h0);
    rd(OFS_STAT, ST_OWN_W);
    wr(OFS_CTL, 8'hc4);
    m_bus.send(d, a);
    check({32'h0, a}, 33'h0);
    rd(OFS_STAT, ST_D_ACK);
    rd(OFS_DATA, d);
    wr(OFS_CTL, 8'h84);
    m_bus.send(~d, a);
    check({32'h0, a}, 33'h1);
    rd(OFS_STAT, ST_D_NACK);
    rd(OFS_DATA, ~d);
    wr(OFS_CTL, 8'ha4);
    m_bus.stop();
    repeat (40) @(posedge clk);
    wr(OFS_CTL, 8'h44);
    ok_case(8'h00, 1'b0, 1'b0, ST_GC, ST_GD_NACK);
    ok_case({own, 1'b0}, 1'b1, 1'b0, ST_ARB_OWN, ST_D_NACK);
    ok_case(8'h00, 1'b1, 1'b0, ST_ARB_GC, ST_GD_NACK);
    ok_case({own, 1'b0}, 1'b0, 1'b1, ST_OWN_W, ST_D_NACK);
    nack_case({own, 1'b1}, ST_D_NACK);
    wr(OFS_CTL, 8'h04);
    nack_case({own, 1'b0}, ST_D_NACK);
    wr(OFS_CTL, 8'h44);
    wr(OFS_OWN, {own, 1'b0});
    nack_case(8'h00, ST_D_NACK);
    ok_case({own, 1'b0}, 1'b0, 1'b0, ST_OWN_W, ST_D_NACK);
    check(33'(n_wake), 33'h1);
    check(33'(n_tx), 33'h1);
    check(33'(n_start), 33'h1);
    end_sim();
  end
endmodule : tb
